// >>> design/epl_defines.svh
`ifndef EPL_DEFINES_SVH
`define EPL_DEFINES_SVH
// register byte offsets
`define EPL_ADR_W 8
`define EPL_OFF_CTRL 8'h00
`define EPL_OFF_PRE_DUAL 8'h04
`define EPL_OFF_PRE_ONE 8'h08
`define EPL_OFF_STATUS 8'h0c
`define EPL_OFF_DATA 8'h10
// control word fields
`define EPL_CTRL_START 0
`define EPL_CTRL_ONE 1
`define EPL_CTRL_DED 2
`define EPL_CTRL_PIN_LO 4
`define EPL_CTRL_PIN_HI 5
`define EPL_CTRL_PS_LO 8
`define EPL_CTRL_PS_HI 11
`define EPL_CTRL_CNT_LO 16
`define EPL_CTRL_CNT_HI 23
// status word fields
`define EPL_ST_DONE 0
`define EPL_ST_BUSY 1
`define EPL_ST_OVF 2
`define EPL_ST_AVAIL 3
`define EPL_ST_FULL 4
`define EPL_ST_CNT_LO 8
`define EPL_ST_CNT_HI 15
// preload and counter values
`define EPL_PRELOAD_RST 16'hffff
`define EPL_PRELOAD_MIN 16'h0001
`define EPL_CNT_TOP 16'hffff
`define EPL_PS_LEGACY_MAX 3'h7
// timer clock: ns per count = 2000 * 2^sel / clock in MHz
`define EPL_TC_SCALE_NS 2000
`define EPL_MCLK_MHZ 100
`define EPL_MCLK_NS 10
`define EPL_TC_BASE_CYC ((`EPL_TC_SCALE_NS / `EPL_MCLK_MHZ) / `EPL_MCLK_NS)
`define EPL_PS_W 20
`endif

// >>> design/epl_pkg.sv
package epl_pkg;
  typedef enum logic [1:0] {epl_idle, epl_run, epl_done} epl_state_t;
  typedef struct packed {
    logic [7:0] req;
    logic [3:0] prescale;
    logic [1:0] pin_sel;
    logic use_ded;
    logic one_counter_option;
  } epl_cfg_t;
endpackage : epl_pkg

// >>> design/epl_fifo.sv
`timescale 1ns/100ps
module epl_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + (AW+1)'(1);
      end
      if (pop)
      begin
        rd_q <= rd_q + (AW+1)'(1);
      end
    end
  end
endmodule : epl_fifo

// >>> design/epl_prescale.sv
`timescale 1ns/100ps
`include "epl_defines.svh"
module epl_prescale (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] sel,
  output logic tick
);
  logic [`EPL_PS_W-1:0] cnt_q;
  logic [`EPL_PS_W-1:0] limit;

  // one timer count lasts base * 2^sel system cycles
  assign limit = `EPL_PS_W'((`EPL_PS_W'(`EPL_TC_BASE_CYC) << sel) - `EPL_PS_W'(1));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (cnt_q >= limit)
    begin
      cnt_q <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + `EPL_PS_W'(1);
      tick <= 1'b0;
    end
  end
endmodule : epl_prescale

// >>> design/epl_logger.sv
// What this block does
// - each edge-to-edge interval is counted in timer ticks, stored as 16-bit word in order.
// - software gives a count; storing stops once that many words were stored.
// - on completion the stored count reads as 8 bits; no interrupt or event.
// - a period longer than the programmed maximum ends the capture at once.
// - maximum per period is 1..65535, default 65535, separate for each configuration.
// - two counters by default; an option uses a single counter.
// - two-counter mode reads the fifth pin only; single mode selects pins five to eight.
// - single mode on fifth pin chooses mux or dedicated counter; others always mux.
// - prescale 0..7 default 0, extended 0..15; runtime setting overrides declared value.
// - arming mid-phase stores that phase first; earlier completed periods are dropped.
// - two periods shorter than the minimum together may lose a measurement.
// - a phase already saturated before arming is not stored; next full period is first.
// - one count lasts 2000 * 2^prescale / clock MHz nanoseconds.
// - overflow on any counter in use ends the measurement series.
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`include "epl_defines.svh"
module epl_logger #(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter bit EXT_PRESCALE = 1'b1,
  parameter logic [3:0] DECL_PRESCALE = 4'h0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] io_pin,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [`EPL_ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack
);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic [15:0] clamp_max(input logic [15:0] v);
    return (v == 16'h0000) ? `EPL_PRELOAD_MIN : v;
  endfunction : clamp_max

  ////////////////////////////////////////////////////////////////////////////////
  epl_pkg::epl_cfg_t cfg_q;
  epl_pkg::epl_cfg_t cfg_d;
  epl_pkg::epl_state_t state_q;
  logic [15:0] pre_dual_q;
  logic [15:0] pre_one_q;
  logic [31:0] ctrl_view;
  logic acc;
  logic wr;
  logic rd;
  logic start;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic lvl_q;
  logic [1:0] eff_pin;
  logic sel_lvl;
  logic edge_p;
  logic [3:0] ps_sel;
  logic tick;
  logic ded_path;
  logic dual;
  logic [1:0] tc_use;
  logic [1:0] tc_run;
  logic [1:0] tc_restart;
  logic [1:0] tc_ovf_ev;
  logic [15:0] cnt_q [2];
  logic ovf_q [2];
  logic [15:0] tc_max;
  logic [15:0] tc_start_val;
  logic meas_idx;
  logic [7:0] stored_q;
  logic end_q;
  logic pend_q;
  logic [15:0] pend_word_q;
  logic store_ev;
  logic finish;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic fifo_pop;
  logic [31:0] status_view;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode: one access per request, answered on the following edge
  assign acc = wb_cyc && wb_stb && !wb_ack;
  assign wr = acc && wb_we;
  assign rd = acc && !wb_we;

  assign ctrl_view = {8'h00, cfg_q.req, 4'h0, cfg_q.prescale, 2'b00, cfg_q.pin_sel,
                      1'b0, cfg_q.use_ded, cfg_q.one_counter_option, 1'b0};

  always_comb
  begin
    logic [31:0] m;
    m = merge_bytes(ctrl_view, wb_dat_w, wb_sel);
    cfg_d = cfg_q;
    cfg_d.one_counter_option = m[`EPL_CTRL_ONE];
    cfg_d.use_ded = m[`EPL_CTRL_DED];
    cfg_d.pin_sel = m[`EPL_CTRL_PIN_HI:`EPL_CTRL_PIN_LO];
    cfg_d.prescale = m[`EPL_CTRL_PS_HI:`EPL_CTRL_PS_LO];
    cfg_d.req = m[`EPL_CTRL_CNT_HI:`EPL_CTRL_CNT_LO];
  end

  // start bit only counts when its byte lane is written
  assign start = wr && (wb_adr == `EPL_OFF_CTRL) && wb_sel[0] &&
                 wb_dat_w[`EPL_CTRL_START];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfg_q <= '{req: 8'h00, prescale: DECL_PRESCALE, pin_sel: 2'b00,
                 use_ded: 1'b0, one_counter_option: 1'b0};
    end
    else if (wr && (wb_adr == `EPL_OFF_CTRL))
    begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pre_dual_q <= `EPL_PRELOAD_RST;
      pre_one_q <= `EPL_PRELOAD_RST;
    end
    else if (wr && (wb_adr == `EPL_OFF_PRE_DUAL))
    begin
      pre_dual_q <= clamp_max(16'(merge_bytes(32'(pre_dual_q), wb_dat_w, wb_sel)));
    end
    else if (wr && (wb_adr == `EPL_OFF_PRE_ONE))
    begin
      pre_one_q <= clamp_max(16'(merge_bytes(32'(pre_one_q), wb_dat_w, wb_sel)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchroniser; first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      lvl_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= io_pin;
      pin_s2_q <= pin_s1_q;
      lvl_q <= sel_lvl;
    end
  end

  assign dual = !cfg_q.one_counter_option;
  assign eff_pin = dual ? 2'b00 : cfg_q.pin_sel;
  assign sel_lvl = pin_s2_q[eff_pin];
  // a pin switch can look like an edge; reconfigure only while idle
  assign edge_p = sel_lvl ^ lvl_q;

  ////////////////////////////////////////////////////////////////////////////////
  // timer base and the two counters: index 0 dedicated, index 1 multiplexed
  assign ps_sel = EXT_PRESCALE ? cfg_q.prescale : {1'b0, cfg_q.prescale[2:0] & `EPL_PS_LEGACY_MAX};

  epl_prescale u_prescale (
    .mclk (mclk),
    .rst (rst),
    .sel (ps_sel),
    .tick (tick)
  );

  assign ded_path = (eff_pin == 2'b00) && cfg_q.use_ded;
  assign tc_use = dual ? 2'b11 : {!ded_path, ded_path};
  // two-counter mode: dedicated times high phases, multiplexed low phases
  assign tc_run = dual ? {!sel_lvl, sel_lvl} : tc_use;
  assign tc_restart = {2{edge_p}} & (dual ? {!sel_lvl, sel_lvl} : tc_use);
  assign tc_max = dual ? pre_dual_q : pre_one_q;
  // counting up from minus the maximum leaves words biased by the preload
  assign tc_start_val = 16'h0000 - tc_max;
  assign meas_idx = dual ? sel_lvl : !ded_path;

  for (genvar i = 0; i < 2; i++)
  begin : g_tc
    assign tc_ovf_ev[i] = tc_run[i] && tick && !ovf_q[i] && !tc_restart[i] &&
                          (cnt_q[i] == `EPL_CNT_TOP);

    // reset leaves counters saturated: no edge seen yet means no valid phase
    always_ff @(posedge mclk)
    begin
      if (rst)
      begin
        cnt_q[i] <= `EPL_CNT_TOP;
        ovf_q[i] <= 1'b1;
      end
      else if (tc_restart[i])
      begin
        cnt_q[i] <= tc_start_val;
        ovf_q[i] <= 1'b0;
      end
      else if (tc_ovf_ev[i])
      begin
        ovf_q[i] <= 1'b1;
      end
      else if (tc_run[i] && tick && !ovf_q[i])
      begin
        cnt_q[i] <= cnt_q[i] + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture sequencing; counters keep timing while idle so arming mid-phase keeps it
  // a saturated counter at an edge only happens for a phase that overflowed before arming
  assign store_ev = (state_q == epl_pkg::epl_run) && !start && edge_p && !end_q &&
                    !ovf_q[meas_idx] && !pend_q && (stored_q != cfg_q.req);
  // a word still waiting for buffer room blocks the next edge; that one is lost
  assign finish = ((stored_q == cfg_q.req) || end_q) && !pend_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= epl_pkg::epl_idle;
    end
    else if (start)
    begin
      state_q <= epl_pkg::epl_run;
    end
    else
    begin
      case (state_q)
        epl_pkg::epl_run:
        begin
          if (finish)
          begin
            state_q <= epl_pkg::epl_done;
          end
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || start)
    begin
      end_q <= 1'b0;
    end
    else if ((state_q == epl_pkg::epl_run) && |(tc_ovf_ev & tc_use) &&
             (stored_q != cfg_q.req))
    begin
      end_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || start)
    begin
      stored_q <= 8'h00;
    end
    else if (store_ev)
    begin
      stored_q <= stored_q + 8'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || start)
    begin
      pend_q <= 1'b0;
      pend_word_q <= 16'h0000;
    end
    else if (store_ev)
    begin
      pend_q <= 1'b1;
      pend_word_q <= cnt_q[meas_idx];
    end
    else if (fifo_in_ready)
    begin
      pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign fifo_pop = rd && (wb_adr == `EPL_OFF_DATA);

  epl_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk (mclk),
    .rst (rst),
    .flush (start),
    .in_valid (pend_q),
    .in_ready (fifo_in_ready),
    .in_data (pend_word_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data (fifo_out_data)
  );

  always_comb
  begin
    status_view = 32'h0000_0000;
    status_view[`EPL_ST_DONE] = (state_q == epl_pkg::epl_done);
    status_view[`EPL_ST_BUSY] = (state_q == epl_pkg::epl_run);
    // shown with done only, so a poll never sees the overflow a cycle ahead of done
    status_view[`EPL_ST_OVF] = end_q && (state_q == epl_pkg::epl_done);
    status_view[`EPL_ST_AVAIL] = fifo_out_valid;
    status_view[`EPL_ST_FULL] = !fifo_in_ready;
    status_view[`EPL_ST_CNT_HI:`EPL_ST_CNT_LO] = stored_q;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end
    else
    begin
      wb_ack <= acc;
      if (rd)
      begin
        case (wb_adr)
          `EPL_OFF_CTRL: wb_dat_r <= ctrl_view;
          `EPL_OFF_PRE_DUAL: wb_dat_r <= {16'h0000, pre_dual_q};
          `EPL_OFF_PRE_ONE: wb_dat_r <= {16'h0000, pre_one_q};
          `EPL_OFF_STATUS: wb_dat_r <= status_view;
          `EPL_OFF_DATA: wb_dat_r <= {16'h0000, fifo_out_valid ? fifo_out_data : 16'h0000};
          default: wb_dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : epl_logger

// >>> bench/epl_src.sv
`timescale 1ns/100ps
module epl_src (
  input wire logic mclk,
  output logic [3:0] io_pin
);
  initial io_pin = 4'h0;
  // holds a level n cycles then flips; callers keep two phases above 1040 cycles, apart from the 20-cycle phase in the overflow test
  task automatic phase(input int p, input int n);
    repeat (n) @(posedge mclk);
    io_pin[p] <= ~io_pin[p];
  endtask : phase
endmodule : epl_src

// >>> bench/epl_logger_props.sv
`timescale 1ns/100ps
`include "epl_defines.svh"
module epl_logger_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] io_pin,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [`EPL_ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack
);
  logic rd_ack, st_rd, start_wr, done_q;
  logic [7:0] req_q, cnt_q;
  assign rd_ack = wb_ack && !wb_we;
  assign st_rd = rd_ack && wb_adr == `EPL_OFF_STATUS;
  assign start_wr = wb_cyc && wb_stb && wb_we && !wb_ack && wb_adr == `EPL_OFF_CTRL
    && wb_sel[0] && wb_dat_w[0];
  always_ff @(posedge mclk)
    if (rst)
      req_q <= 8'h00;
    else if (start_wr)
      req_q <= wb_dat_w[23:16];
  // remembers the first done report so later reads can be held to it
  always_ff @(posedge mclk)
    if (rst || start_wr)
      done_q <= 1'b0;
    else if (st_rd && wb_dat_r[0] && !done_q)
      done_q <= 1'b1;
  always_ff @(posedge mclk)
    if (st_rd && !done_q)
      cnt_q <= wb_dat_r[15:8];
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_ack_pulse;
    wb_ack |=> !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_answer;
    wb_cyc && wb_stb && !wb_ack |=> wb_ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_ack_cause;
    $rose(wb_ack) |-> $past(wb_cyc && wb_stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_done_holds;
    st_rd && done_q |-> wb_dat_r[0] && wb_dat_r[15:8] == cnt_q;
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("done or count changed");
  property p_cnt_width;
    st_rd |-> wb_dat_r[31:16] == 16'h0000 && wb_dat_r[7:5] == 3'h0;
  endproperty
  a_cnt_width: assert property (p_cnt_width) else $error("status spare bits set");
  property p_full_count;
    st_rd && wb_dat_r[0] && !wb_dat_r[2] |-> wb_dat_r[15:8] == req_q;
  endproperty
  a_full_count: assert property (p_full_count) else $error("count differs from request");
  property p_short_count;
    st_rd && wb_dat_r[2] |-> wb_dat_r[0] && wb_dat_r[15:8] < req_q;
  endproperty
  a_short_count: assert property (p_short_count) else $error("overflow count not short");
  property p_word_width;
    rd_ack && wb_adr == `EPL_OFF_DATA |-> wb_dat_r[31:16] == 16'h0000;
  endproperty
  a_word_width: assert property (p_word_width) else $error("data word wider than 16");
  property p_preload_range;
    rd_ack && (wb_adr == `EPL_OFF_PRE_DUAL || wb_adr == `EPL_OFF_PRE_ONE)
      |-> wb_dat_r[31:16] == 16'h0000 && wb_dat_r[15:0] != 16'h0000;
  endproperty
  a_preload_range: assert property (p_preload_range) else $error("preload out of range");
  property p_not_both;
    st_rd |-> !(wb_dat_r[0] && wb_dat_r[1]);
  endproperty
  a_not_both: assert property (p_not_both) else $error("done and busy together");
endmodule : epl_logger_props
bind epl_logger epl_logger_props u_epl_logger_props (.mclk(mclk), .rst(rst), .io_pin(io_pin),
  .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
  .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

// >>> bench/epl_logger_tb.sv
`timescale 1ns/100ps
module epl_logger_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] v;
    logic tol;
    logic use_it;
  } epl_note_t;
  logic mclk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, io_pin;
  logic [31:0] wb_dat_w, wb_dat_r, rd_v;
  logic [15:0] lfsr_q, dv;
  logic tick_ok;
  epl_note_t nt;
  epl_note_t notes[$];
  int cyc[8];
  int tk[8];
  int mismatches, n_compared;
  epl_logger u_epl_logger (.mclk(mclk), .rst(rst), .io_pin(io_pin), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));
  epl_src u_epl_src (.mclk(mclk), .io_pin(io_pin));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [7:0] a);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected word at %h: expected %h, seen %h", a, exp, got);
    end
  endtask : chk
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] cw(input logic [7:0] r, input logic [3:0] ps,
    input logic [1:0] p, input logic d, input logic o, input logic s);
    return {8'h00, r, 4'h0, ps, 2'h0, p, 1'b0, d, o, s};
  endfunction : cw
  function automatic logic [31:0] st(input logic [7:0] n, input logic o);
    return {16'h0000, n, 4'h0, 1'b1, o, 2'h1};
  endfunction : st
  ////////////////////////////////////////////////////////////////
  // no cycle limit here: only the watchdog ends a hung access
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat_w <= d;
    do @(posedge mclk); while (wb_ack !== 1'b1);
    rd_v = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic t, input logic u);
    notes.push_back({a, e, t, u});
    bus(1'b0, a, 32'h0);
  endtask : rd
  // phase lengths are whole ticks so a word may only be off by one tick of prescaler phase
  task automatic gen(input int ps);
    for (int k = 0; k < 8; k++)
    begin
      lfsr_q = lfsr(lfsr_q);
      tk[k] = ((600 + lfsr_q[6:0]) >> (ps + 1)) + 2;
      cyc[k] = tk[k] << (ps + 1);
    end
  endtask : gen
  task automatic drive(input int p, input int n);
    for (int k = 0; k < n; k++)
      u_epl_src.phase(p, cyc[k]);
  endtask : drive
  task automatic arm(input int p, input int n, input logic [31:0] c);
    u_epl_src.phase(p, 0);
    fork
      drive(p, n);
    join_none
    repeat (50) @(posedge mclk);
    wr(8'h00, c);
  endtask : arm
  task automatic wait_done();
    int k;
    k = 0;
    do
    begin
      rd(8'h0c, 32'h0, 1'b0, 1'b0);
      k++;
    end
    while (rd_v[0] !== 1'b1 && k < 5000);
    if (k >= 5000)
    begin
      mismatches++;
      conclude();
    end
  endtask : wait_done
  task automatic words(input int f, input int n, input logic [15:0] p);
    for (int k = 0; k < n; k++)
      rd(8'h10, {16'h0000, 16'(tk[f + k]) - p}, 1'b1, 1'b1);
    rd(8'h10, 32'h0, 1'b0, 1'b1);
  endtask : words
  ////////////////////////////////////////////////////////////////
  always @(posedge mclk)
    if (wb_ack === 1'b1 && wb_we === 1'b0 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      dv = wb_dat_r[15:0] - nt.v[15:0];
      // a word may sit one tick off because the prescaler phase is free running
      tick_ok = nt.tol && wb_dat_r[31:16] === 16'h0000 && (dv <= 16'h0001 || dv == 16'hffff);
      if (nt.use_it)
        chk(tick_ok ? nt.v : wb_dat_r, nt.v, nt.a);
    end
  initial
  begin
    // all scenarios need about 25000 cycles
    repeat (60000) @(posedge mclk);
    mismatches++;
    conclude();
  end
  initial
  begin
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat_w = 32'h0;
    lfsr_q = 16'h003d;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(8'h04, 32'h0000ffff, 1'b0, 1'b1);
    rd(8'h08, 32'h0000ffff, 1'b0, 1'b1);
    rd(8'h00, 32'h0, 1'b0, 1'b1);
    rd(8'h0c, 32'h0, 1'b0, 1'b1);
    rd(8'h14, 32'h0, 1'b0, 1'b1);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h1, 1'b0, 1'b1);
    wr(8'h04, 32'h0800);
    wr(8'h08, 32'h0300);
    $display("test reset values done");
    gen(0);
    arm(0, 4, cw(8'h04, 4'h0, 2'h0, 1'b0, 1'b0, 1'b1));
    wait_done();
    rd(8'h0c, st(8'h04, 1'b0), 1'b0, 1'b1);
    words(0, 4, 16'h0800);
    $display("test two counter capture done");
    // level held past the overflow period so the phase before the first edge is dropped
    repeat (5000) @(posedge mclk);
    gen(0);
    cyc[0] = 20;
    wr(8'h00, cw(8'h08, 4'h0, 2'h0, 1'b0, 1'b0, 1'b1));
    fork
      drive(0, 3);
    join_none
    wait_done();
    rd(8'h0c, st(8'h02, 1'b1), 1'b0, 1'b1);
    words(1, 2, 16'h0800);
    $display("test overflow end done");
    for (int i = 0; i < 4; i++)
    begin
      gen(3 * i);
      // dedicated flag on the sixth pin too: that pin must still use the multiplexed counter
      wr(8'h00, cw(8'h02, 4'(3 * i), 2'(i), i < 2, 1'b1, 1'b0));
      rd(8'h00, cw(8'h02, 4'(3 * i), 2'(i), i < 2, 1'b1, 1'b0), 1'b0, 1'b1);
      arm(i, 2, cw(8'h02, 4'(3 * i), 2'(i), i < 2, 1'b1, 1'b1));
      wait_done();
      rd(8'h0c, st(8'h02, 1'b0), 1'b0, 1'b1);
      words(0, 2, 16'h0300);
    end
    $display("test single counter pins done");
    conclude();
  end
endmodule : epl_logger_tb
